// File: design/hims_top.sv
// Strap decode and host pin routing for the display driver host port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RQ1) Bus-style strap high gives 6800, else 8080
// (RQ2) Straps 1,0,0 select 8-bit parallel port
// (RQ3) Mode high 0, wire strap 1: 4-line serial
// (RQ4) Wire strap 0: 3-line or two-data-line serial
// (RQ5) Host grounds bus-style strap when unused
// (RQ6) Chip reset is active low, glitch free
// (RQ7) Chip select low enables host port
// (RQ8) Parallel flag: 1 data, 0 command
// (RQ9) Serial modes use flag pin as clock
// (RQ10) 8080: read strobe reads, write strobe writes
// (RQ11) 6800: write pin picks strobe direction
// (RQ12) 4-line serial: write strobe is cmd/data
// (RQ13) Two-data-line: write strobe is second data
// (RQ14) Serial without RGB: bus bit 0 is data
// (RQ15) Serial with RGB: low six bits pixels
// (RQ16) RGB on: serial data on dedicated pin
// (RQ17) Parallel: all eight bits form data bus
// (RQ18) Dedicated serial pin used only with RGB
// (RQ19) Host supplies pixel clock, syncs, enable
// (RQ20) Tearing sync output drives host timing
// (RQ21) Resolution straps select panel size
// (RQ22) Unlisted strap codes are reserved
module hims_top
  import hims_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic pixel_clk,
  input wire logic bus_style_strap,
  input wire logic iface_mode_strap_hi,
  input wire logic iface_mode_strap_mid,
  input wire logic iface_mode_strap_lo,
  input wire logic serial_wire_count_strap,
  input wire logic rgb_port_enable_strap,
  input wire logic panel_size_strap_hi,
  input wire logic panel_size_strap_mid,
  input wire logic panel_size_strap_lo,
  input wire logic two_line_enable,
  input wire logic chip_reset_n,
  input wire logic chip_select_n,
  input wire logic cmd_data_flag_pin,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [HIMS_DATA_W-1:0] data_bus_in,
  output logic [HIMS_DATA_W-1:0] data_bus_out,
  output logic [HIMS_DATA_W-1:0] data_bus_oe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic pixel_valid_in,
  input wire logic frame_tick,
  output logic tearing_sync_out,
  input wire logic [HIMS_DATA_W-1:0] core_rd_data,
  input wire logic core_rd_drive,
  input wire logic core_ser_out,
  input wire logic core_ser_drive,
  output hims_mode_t mode,
  output hims_panel_t panel,
  output logic rgb_enabled,
  output logic host_active,
  output logic par_wr_en,
  output logic par_rd_en,
  output logic par_is_data,
  output logic [HIMS_DATA_W-1:0] par_data,
  output logic ser_clk,
  output logic ser_dc,
  output logic ser_din,
  output logic ser_din2,
  output logic [HIMS_RGB_W-1:0] rgb_pixel,
  output logic rgb_line_sync,
  output logic rgb_frame_sync,
  output logic rgb_pixel_valid,
  output logic [8:0] src_first,
  output logic [8:0] src_last,
  output logic [7:0] gate_first,
  output logic [7:0] gate_last
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = 14 + HIMS_DATA_W;
  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_sync;
  logic s_p68, s_im_hi, s_im_mid, s_im_lo, s_wire4, s_rgb;
  logic s_gm_hi, s_gm_mid, s_gm_lo, s_rst_n, s_cs_n, s_dcf, s_rd_n, s_wr_n;
  logic [HIMS_DATA_W-1:0] s_data;
  // Pin order here and in the unpacking below must match
  assign pins_async = {
    bus_style_strap,
    iface_mode_strap_hi,
    iface_mode_strap_mid,
    iface_mode_strap_lo,
    serial_wire_count_strap,
    rgb_port_enable_strap,
    panel_size_strap_hi,
    panel_size_strap_mid,
    panel_size_strap_lo,
    chip_reset_n,
    chip_select_n,
    cmd_data_flag_pin,
    read_strobe_n,
    write_strobe_n,
    data_bus_in
  };
  assign {
    s_p68,
    s_im_hi,
    s_im_mid,
    s_im_lo,
    s_wire4,
    s_rgb,
    s_gm_hi,
    s_gm_mid,
    s_gm_lo,
    s_rst_n,
    s_cs_n,
    s_dcf,
    s_rd_n,
    s_wr_n,
    s_data
  } = pins_sync;
  hims_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .clk(sys_clk),
    .rst(rst),
    .ce(clk_en),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );
  logic s_sdl;
  logic sdl_meta;
  // Dedicated serial pin joins late; same two-stage treatment
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sdl_meta <= 1'b0;
      s_sdl <= 1'b0;
    end else if (clk_en) begin
      sdl_meta <= serial_data_line_in;
      s_sdl <= sdl_meta;
    end
  end
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  hims_mode_t next_mode;
  hims_panel_t next_panel;
  logic is_par, is_ser;
  always_comb begin
    next_mode = HIMS_MODE_NONE; // RQ22
    if ({s_im_hi, s_im_mid, s_im_lo} == HIMS_IM_PARALLEL) begin
      next_mode = s_p68 ? HIMS_MODE_P6800 : HIMS_MODE_P8080; // RQ1 RQ2 RQ5
    end else if (!s_im_hi) begin
      if (s_wire4) begin
        next_mode = HIMS_MODE_SER4; // RQ3
      end else begin
        next_mode = two_line_enable ? HIMS_MODE_SER2 : HIMS_MODE_SER3; // RQ4
      end
    end
  end
  always_comb begin
    unique case ({s_gm_hi, s_gm_mid, s_gm_lo}) // RQ21
      3'h0: next_panel = HIMS_PANEL_132X162;
      3'h1: next_panel = HIMS_PANEL_128X128;
      3'h2: next_panel = HIMS_PANEL_120X160;
      3'h3: next_panel = HIMS_PANEL_128X160;
      3'h4: next_panel = HIMS_PANEL_130X130;
      3'h5: next_panel = HIMS_PANEL_132X132;
      default: next_panel = HIMS_PANEL_RSVD; // RQ22
    endcase
  end
  // Straps are caught on every clock with clk_en high after release, never under reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= HIMS_MODE_NONE;
      panel <= HIMS_PANEL_132X162;
      rgb_enabled <= 1'b0;
    end else if (clk_en) begin
      mode <= next_mode;
      panel <= next_panel;
      rgb_enabled <= s_rgb;
    end
  end
  assign is_par = (mode == HIMS_MODE_P8080) || (mode == HIMS_MODE_P6800);
  assign is_ser = (mode == HIMS_MODE_SER4) || (mode == HIMS_MODE_SER3) ||
                  (mode == HIMS_MODE_SER2);
  // ----------------------------------------
  // Panel windows
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_first <= 9'h000;
      src_last <= 9'h000;
      gate_first <= 8'h00;
      gate_last <= 8'h00;
    end else if (clk_en) begin
      if (panel == HIMS_PANEL_RSVD) begin
        src_first <= 9'h000; // RQ22
        src_last <= 9'h000;
        gate_first <= 8'h00;
        gate_last <= 8'h00;
      end else begin
        src_first <= HIMS_SRC_FIRST[panel]; // RQ21
        src_last <= HIMS_SRC_LAST[panel];
        gate_first <= HIMS_GATE_FIRST[panel];
        gate_last <= HIMS_GATE_LAST[panel];
      end
    end
  end
  // ----------------------------------------
  // Host pin routing
  // ----------------------------------------
  logic act;
  assign act = s_rst_n && !s_cs_n; // RQ6 RQ7
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_active <= 1'b0;
      par_wr_en <= 1'b0;
      par_rd_en <= 1'b0;
      par_is_data <= 1'b0;
      par_data <= '0;
    end else if (clk_en) begin
      host_active <= act; // RQ7
      par_is_data <= is_par && act && s_dcf; // RQ8
      par_data <= (is_par && act) ? s_data : '0; // RQ17
      if (!(is_par && act)) begin
        par_wr_en <= 1'b0;
        par_rd_en <= 1'b0;
      end else if (mode == HIMS_MODE_P8080) begin
        par_wr_en <= !s_wr_n; // RQ10
        par_rd_en <= !s_rd_n;
      end else begin
        par_wr_en <= !s_wr_n && !s_rd_n; // RQ11
        par_rd_en <= s_wr_n && !s_rd_n;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser_clk <= 1'b0;
      ser_dc <= 1'b0;
      ser_din <= 1'b0;
      ser_din2 <= 1'b0;
    end else if (clk_en) begin
      // Oversampled serial clock; host must keep it well below sys_clk / 4
      ser_clk <= is_ser && act && s_dcf; // RQ9
      ser_dc <= (mode == HIMS_MODE_SER4) && act && s_wr_n; // RQ12
      ser_din2 <= (mode == HIMS_MODE_SER2) && act && s_wr_n; // RQ13
      if (!(is_ser && act)) begin
        ser_din <= 1'b0;
      end else if (rgb_enabled) begin
        ser_din <= s_sdl; // RQ16 RQ18
      end else begin
        ser_din <= s_data[HIMS_SER_BIT]; // RQ14
      end
    end
  end
  // Output enables: readback only while selected and in the right mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_bus_out <= '0;
      data_bus_oe <= '0;
      serial_data_line_out <= 1'b0;
      serial_data_line_oe <= 1'b0;
    end else if (clk_en) begin
      serial_data_line_out <= core_ser_out;
      serial_data_line_oe <= is_ser && act && rgb_enabled && core_ser_drive; // RQ18
      if (is_par && act && core_rd_drive && s_wr_n && !s_rd_n) begin
        data_bus_out <= core_rd_data; // RQ17
        data_bus_oe <= '1;
      end else if (is_ser && act && !rgb_enabled && core_ser_drive) begin
        data_bus_out <= {{(HIMS_DATA_W-1){1'b0}}, core_ser_out}; // RQ14
        data_bus_oe <= {{(HIMS_DATA_W-1){1'b0}}, 1'b1};
      end else begin
        data_bus_out <= '0;
        data_bus_oe <= '0;
      end
    end
  end
  // ----------------------------------------
  // RGB port, pixel clock domain
  // ----------------------------------------
  logic rgb_live;
  logic rgb_en_m, rgb_en_px;
  logic ce_m, ce_px;
  logic [HIMS_RGB_W+2:0] rgb_cap;
  // One flopped level crosses, so no decode glitch reaches the pixel side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rgb_live <= 1'b0;
    end else if (clk_en) begin
      rgb_live <= rgb_enabled && is_ser; // RQ15
    end
  end
  // Level crossings into the pixel domain; capture starts two pixel edges late
  always_ff @(posedge pixel_clk or posedge rst) begin
    if (rst) begin
      rgb_en_m <= 1'b0;
      rgb_en_px <= 1'b0;
      ce_m <= 1'b0;
      ce_px <= 1'b0;
    end else begin
      rgb_en_m <= rgb_live;
      rgb_en_px <= rgb_en_m;
      ce_m <= clk_en;
      ce_px <= ce_m;
    end
  end
  always_ff @(posedge pixel_clk or posedge rst) begin
    if (rst) begin
      rgb_cap <= '0;
    end else if (ce_px) begin
      if (rgb_en_px) begin
        rgb_cap <= {line_sync_in, frame_sync_in, pixel_valid_in,
                    data_bus_in[HIMS_RGB_W-1:0]}; // RQ15 RQ19
      end else begin
        rgb_cap <= '0;
      end
    end
  end
  // Captured pixel word handed over as registered outputs on pixel clock
  always_ff @(posedge pixel_clk or posedge rst) begin
    if (rst) begin
      rgb_line_sync <= 1'b0;
      rgb_frame_sync <= 1'b0;
      rgb_pixel_valid <= 1'b0;
      rgb_pixel <= '0;
    end else if (ce_px) begin
      {rgb_line_sync, rgb_frame_sync, rgb_pixel_valid, rgb_pixel} <= rgb_cap;
    end
  end
  // ----------------------------------------
  // Tearing sync
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tearing_sync_out <= 1'b0;
    end else if (clk_en) begin
      tearing_sync_out <= frame_tick && s_rst_n; // RQ20
    end
  end
endmodule
`default_nettype wire

// File: design/hims_pkg.sv
// Constants and types for the host interface mode select block
package hims_pkg;
  // ----------------------------------------
  // Interface modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    HIMS_MODE_NONE = 3'h0,
    HIMS_MODE_P8080 = 3'h1,
    HIMS_MODE_P6800 = 3'h3,
    HIMS_MODE_SER4 = 3'h2,
    HIMS_MODE_SER3 = 3'h6,
    HIMS_MODE_SER2 = 3'h7
  } hims_mode_t;
  // ----------------------------------------
  // Panel sizes
  // ----------------------------------------
  typedef enum logic [2:0] {
    HIMS_PANEL_132X162 = 3'h0,
    HIMS_PANEL_128X128 = 3'h1,
    HIMS_PANEL_120X160 = 3'h2,
    HIMS_PANEL_128X160 = 3'h3,
    HIMS_PANEL_130X130 = 3'h4,
    HIMS_PANEL_132X132 = 3'h5,
    HIMS_PANEL_RSVD = 3'h7
  } hims_panel_t;
  localparam logic [2:0] HIMS_IM_PARALLEL = 3'h4;
  localparam int HIMS_DATA_W = 8;
  localparam int HIMS_RGB_W = 6;
  localparam int HIMS_SYNC_W = 4;
  localparam int HIMS_SER_BIT = 0;
  // Source and gate windows per panel code
  localparam logic [8:0] HIMS_SRC_FIRST [0:5] = '{9'h001, 9'h007, 9'h007, 9'h007, 9'h007, 9'h001};
  localparam logic [8:0] HIMS_SRC_LAST [0:5] = '{9'h18c, 9'h186, 9'h16e, 9'h186, 9'h18c, 9'h18c};
  localparam logic [7:0] HIMS_GATE_FIRST [0:5] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
  localparam logic [7:0] HIMS_GATE_LAST [0:5] = '{8'ha2, 8'h81, 8'ha1, 8'ha1, 8'h83, 8'h85};
endpackage

// File: design/hims_sync.sv
// Two flip-flop synchroniser bank
`timescale 1ns/1ps
`default_nettype none
module hims_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: tb/hims_asserts.sv
// Concurrent checks on the host interface mode select ports
`timescale 1ns/1ps
`default_nettype none
module hims_asserts
  import hims_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic bus_style_strap,
  input wire logic iface_mode_strap_hi,
  input wire logic iface_mode_strap_mid,
  input wire logic iface_mode_strap_lo,
  input wire logic serial_wire_count_strap,
  input wire logic two_line_enable,
  input wire logic rgb_port_enable_strap,
  input wire logic panel_size_strap_hi,
  input wire logic panel_size_strap_mid,
  input wire logic panel_size_strap_lo,
  input wire logic chip_reset_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic frame_tick,
  input wire logic tearing_sync_out,
  input wire hims_mode_t mode,
  input wire hims_panel_t panel,
  input wire logic rgb_enabled,
  input wire logic host_active,
  input wire logic par_wr_en,
  input wire logic par_rd_en,
  input wire logic [8:0] src_first,
  input wire logic [7:0] gate_last
);
  logic [5:0] strap;
  logic [2:0] gm;
  hims_mode_t exp_mode;
  assign strap = {bus_style_strap, iface_mode_strap_hi, iface_mode_strap_mid,
    iface_mode_strap_lo, serial_wire_count_strap, two_line_enable};
  assign gm = {panel_size_strap_hi, panel_size_strap_mid, panel_size_strap_lo};
  // Reserved codes land on the idle mode so nothing downstream acts on them
  always_comb begin
    if (strap[4]) exp_mode = (strap[3:2] != 2'b00) ? HIMS_MODE_NONE :
      (strap[5] ? HIMS_MODE_P6800 : HIMS_MODE_P8080);
    else exp_mode = strap[1] ? HIMS_MODE_SER4 :
      (strap[0] ? HIMS_MODE_SER2 : HIMS_MODE_SER3);
  end
  default clocking @(posedge sys_clk); endclocking
  // A frozen clock enable stalls every sys_clk pipeline, so checks pause with it
  default disable iff (rst || !clk_en);
  mode_decode_a: assert property ($stable(strap)[*5] |-> mode == exp_mode)
    else $error("mode does not follow straps");
  panel_decode_a: assert property ($stable(gm)[*5] |-> panel == ((gm < 3'h6) ? gm : 3'h7))
    else $error("panel does not follow straps");
  panel_window_a: assert property ($stable(panel)[*5] ##0 panel != HIMS_PANEL_RSVD |->
    src_first == HIMS_SRC_FIRST[panel] && gate_last == HIMS_GATE_LAST[panel])
    else $error("panel window wrong");
  rgb_follow_a: assert property ($stable(rgb_port_enable_strap)[*5] |->
    rgb_enabled == rgb_port_enable_strap)
    else $error("rgb enable does not follow strap");
  host_off_a: assert property ((chip_select_n || !chip_reset_n)[*4] |->
    !host_active && !par_wr_en && !par_rd_en)
    else $error("host port active while deselected");
  write_8080_a: assert property ((mode == HIMS_MODE_P8080 && !chip_select_n && chip_reset_n
    && !write_strobe_n && read_strobe_n)[*4] |-> par_wr_en && !par_rd_en)
    else $error("8080 write not routed");
  read_6800_a: assert property ((mode == HIMS_MODE_P6800 && !chip_select_n && chip_reset_n
    && write_strobe_n && !read_strobe_n)[*4] |-> par_rd_en && !par_wr_en)
    else $error("6800 read not routed");
  tearing_out_a: assert property (chip_reset_n[*4] |=> tearing_sync_out == $past(frame_tick))
    else $error("tearing output wrong");
endmodule
bind hims_top hims_asserts u_asserts (.*);
`default_nettype wire

// File: tb/hims_host_model.sv
// Host microcontroller model driving the parallel and serial host pins
`timescale 1ns/1ps
`default_nettype none
module hims_host_model
  import hims_pkg::*;
(
  input wire logic sys_clk,
  output logic chip_select_n,
  output logic cmd_data_flag_pin,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [HIMS_DATA_W-1:0] data_bus_in,
  input wire logic [HIMS_DATA_W-1:0] data_bus_out,
  input wire logic [HIMS_DATA_W-1:0] data_bus_oe
);
  logic [HIMS_DATA_W-1:0] host_drv;
  logic host_oe;
  // Released bus shows the inverse of the last value, never a stale copy
  assign data_bus_in = (data_bus_oe & data_bus_out) |
    (~data_bus_oe & (host_oe ? host_drv : ~host_drv));
  // Caller holds each phase for several clocks; strobes are active low
  task automatic start(input logic m68, input logic rd, input logic dc, input logic [7:0] d);
    chip_select_n = 1'b0;
    cmd_data_flag_pin = dc;
    write_strobe_n = rd;
    read_strobe_n = m68 ? 1'b0 : !rd;
    host_drv = d;
    host_oe = !rd;
  endtask
  task automatic stop();
    {chip_select_n, read_strobe_n, write_strobe_n, host_oe} = 4'b1110;
  endtask
  task automatic ser(input logic sck, input logic dc, input logic [7:0] d);
    chip_select_n = 1'b0;
    cmd_data_flag_pin = sck;
    write_strobe_n = dc;
    host_drv = d;
    host_oe = 1'b1;
  endtask
  initial begin
    {chip_select_n, cmd_data_flag_pin, read_strobe_n, write_strobe_n, host_oe} = 5'b10110;
    host_drv = 8'h00;
  end
endmodule
`default_nettype wire

// File: tb/hims_top_bench.sv
// Self-checking bench for the host interface mode select block
`timescale 1ns/1ps
`default_nettype none
module hims_top_bench
  import hims_pkg::*;
;
  logic sys_clk, rst, clk_en, pixel_clk, pclk_run, bus_style_strap, iface_mode_strap_hi;
  logic iface_mode_strap_mid, iface_mode_strap_lo, serial_wire_count_strap, two_line_enable;
  logic rgb_port_enable_strap, panel_size_strap_hi, panel_size_strap_mid, panel_size_strap_lo;
  logic chip_reset_n, serial_data_line_in, line_sync_in, frame_sync_in, pixel_valid_in;
  logic frame_tick, core_rd_drive, core_ser_out, core_ser_drive;
  logic [7:0] core_rd_data;
  wire logic chip_select_n, cmd_data_flag_pin, read_strobe_n, write_strobe_n;
  wire logic [7:0] data_bus_in, data_bus_out, data_bus_oe, par_data;
  wire logic serial_data_line_out, serial_data_line_oe, tearing_sync_out, rgb_enabled;
  wire logic host_active, par_wr_en, par_rd_en, par_is_data, ser_clk, ser_dc, ser_din, ser_din2;
  wire logic [5:0] rgb_pixel;
  wire logic rgb_line_sync, rgb_frame_sync, rgb_pixel_valid;
  wire logic [8:0] src_first, src_last;
  wire logic [7:0] gate_first, gate_last;
  wire hims_mode_t mode;
  wire hims_panel_t panel;
  int n_fail = 0;
  int samples_checked = 0;
  logic [5:0] mt_in [0:7] = '{6'b010000, 6'b110000, 6'b010010, 6'b000010, 6'b000110,
    6'b000100, 6'b000001, 6'b011000};
  hims_mode_t mt_exp [0:7] = '{HIMS_MODE_P8080, HIMS_MODE_P6800, HIMS_MODE_P8080,
    HIMS_MODE_SER4, HIMS_MODE_SER4, HIMS_MODE_SER3, HIMS_MODE_SER2, HIMS_MODE_NONE};
  hims_top u_dut (.*);
  hims_host_model u_host (.sys_clk, .chip_select_n, .cmd_data_flag_pin, .read_strobe_n,
    .write_strobe_n, .data_bus_in, .data_bus_out, .data_bus_oe);
  always #2 sys_clk = ~sys_clk;
  // Pixel clock only runs while a frame is being sent
  always #24 if (pclk_run) pixel_clk = ~pixel_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic straps(input logic [5:0] s);
    {bus_style_strap, iface_mode_strap_hi, iface_mode_strap_mid, iface_mode_strap_lo,
      serial_wire_count_strap, two_line_enable} = s;
    cyc(6);
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  initial begin
    {sys_clk, pixel_clk, pclk_run, frame_tick, core_rd_drive, core_ser_out, core_ser_drive} = '0;
    {bus_style_strap, iface_mode_strap_hi, iface_mode_strap_mid, iface_mode_strap_lo} = '0;
    {serial_wire_count_strap, two_line_enable, rgb_port_enable_strap, serial_data_line_in} = '0;
    {panel_size_strap_hi, panel_size_strap_mid, panel_size_strap_lo, line_sync_in} = '0;
    {frame_sync_in, pixel_valid_in, core_rd_data} = '0;
    {rst, clk_en, chip_reset_n} = 3'b111;
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    cyc(6);
    for (int i = 0; i < 8; i++) begin
      straps(mt_in[i]);
      chk(mode, mt_exp[i]);
    end
    for (int i = 0; i < 8; i++) begin
      {panel_size_strap_hi, panel_size_strap_mid, panel_size_strap_lo} = 3'(i);
      cyc(6);
      chk(panel, (i < 6) ? 16'(i) : 16'h7);
      if (i == 0 || i == 2) begin
        chk({src_first, 7'h00}, {(i > 0) ? 9'h007 : 9'h001, 7'h00});
        chk(16'(src_last), (i > 0) ? 16'h016e : 16'h018c);
        chk(16'(gate_first), (i > 0) ? 16'h0002 : 16'h0001);
        chk(gate_last, (i > 0) ? 16'ha1 : 16'ha2);
      end
    end
    // Frozen clock enable must hold the decoded panel
    clk_en = 1'b0;
    {panel_size_strap_hi, panel_size_strap_mid, panel_size_strap_lo} = 3'h1;
    cyc(6);
    chk(panel, HIMS_PANEL_RSVD);
    clk_en = 1'b1;
    cyc(6);
    chk(panel, HIMS_PANEL_128X128);
    for (int m = 0; m < 2; m++) begin
      straps(m ? 6'b110000 : 6'b010000);
      for (int r = 0; r < 2; r++) begin
        core_rd_drive = r[0];
        core_rd_data = 8'h3c ^ 8'(m);
        u_host.start(m[0], r[0], m[0], 8'ha5);
        cyc(6);
        chk({host_active, par_wr_en, par_rd_en}, {1'b1, !r[0], r[0]});
        if (r) chk({data_bus_oe, data_bus_out}, {8'hff, 8'h3c ^ 8'(m)});
        else chk({par_is_data, par_data}, {m[0], 8'ha5});
        u_host.stop();
        cyc(6);
        chk({host_active, par_wr_en, par_rd_en, data_bus_oe}, '0);
      end
    end
    // Held reset must also mask the tearing output
    {chip_reset_n, frame_tick} = 2'b01;
    u_host.start(1'b1, 1'b0, 1'b1, 8'h11);
    cyc(6);
    chk({host_active, par_wr_en, tearing_sync_out}, '0);
    {chip_reset_n, frame_tick} = 2'b10;
    u_host.stop();
    for (int j = 0; j < 2; j++) begin
      straps(j ? 6'b000001 : 6'b000010);
      for (int v = 0; v < 2; v++) begin
        u_host.ser(v[0], !v[0], {7'h2a, v[0]});
        cyc(6);
        chk({ser_clk, j ? ser_din2 : ser_dc, ser_din}, {v[0], !v[0], v[0]});
      end
    end
    {core_ser_out, core_ser_drive} = 2'b11;
    cyc(6);
    chk({data_bus_oe, data_bus_out}, 16'h0101);
    chk({serial_data_line_oe, serial_data_line_out}, 2'b01);
    {rgb_port_enable_strap, serial_data_line_in, line_sync_in, frame_sync_in} = 4'b1110;
    pixel_valid_in = 1'b1;
    u_host.ser(1'b0, 1'b1, 8'h2c);
    straps(6'b000000);
    chk({rgb_enabled, ser_din}, 2'b11);
    chk({serial_data_line_oe, serial_data_line_out, data_bus_oe}, 10'h300);
    pclk_run = 1'b1;
    repeat (6) @(posedge pixel_clk);
    #1;
    pclk_run = 1'b0;
    chk({rgb_pixel, rgb_line_sync, rgb_frame_sync, rgb_pixel_valid}, {6'h2c, 3'b101});
    cyc(1);
    frame_tick = 1'b1;
    cyc(1);
    chk(tearing_sync_out, 1'b1);
    frame_tick = 1'b0;
    cyc(1);
    chk(tearing_sync_out, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
